/* rtl/pcd_mux.sv */
`timescale 1ns/100ps
`include "pcd_cfg.svh"

module pcd_mux (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic RESET_PIN_DISABLE_FUSE,
  input wire logic GLOBAL_PULLUP_DISABLE,
  input wire logic INPUT_SLEEP_DISABLE,
  input wire logic [`PCD_NPC-1:0] PORTC_OUTPUT,
  input wire logic [`PCD_NPC-1:0] PORTC_DIRECTION,
  input wire logic [`PCD_NPD-1:0] PORTD_OUTPUT,
  input wire logic [`PCD_NPD-1:0] PORTD_DIRECTION,
  input wire logic TWO_WIRE_ENABLE,
  input wire logic TWO_WIRE_CLOCK_DRIVE,
  input wire logic TWO_WIRE_DATA_DRIVE,
  input wire logic TRANSMITTER_ENABLE,
  input wire logic TRANSMIT_DATA,
  input wire logic RECEIVER_ENABLE,
  input wire logic USART_MODE_SELECT,
  input wire logic USART_EXTERNAL_CLOCK_OUT,
  input wire logic EXTERNAL_INTERRUPT_0_ENABLE,
  input wire logic EXTERNAL_INTERRUPT_1_ENABLE,
  input wire logic [`PCD_NPC-1:0] PORTC_PAD_IN,
  input wire logic [`PCD_NPD-1:0] PORTD_PAD_IN,
  output logic [`PCD_NPC-1:0] PORTC_PAD_OUT,
  output logic [`PCD_NPC-1:0] PORTC_PAD_OE_N,
  output logic [`PCD_NPC-1:0] PORTC_PULLUP,
  output logic [`PCD_NPD-1:0] PORTD_PAD_OUT,
  output logic [`PCD_NPD-1:0] PORTD_PAD_OE_N,
  output logic [`PCD_NPD-1:0] PORTD_PULLUP,
  output logic [`PCD_NPC-1:0] PORTC_INPUT,
  output logic [`PCD_NPC-1:0] PORTC_OUTPUT_READ,
  output logic [`PCD_NPC-1:0] PORTC_DIRECTION_READ,
  output logic [`PCD_NPD-1:0] PORTD_INPUT,
  output logic RESET_PIN_N,
  output logic TWO_WIRE_CLOCK_IN,
  output logic TWO_WIRE_DATA_IN,
  output logic RECEIVE_DATA,
  output logic USART_EXTERNAL_CLOCK_IN,
  output logic TIMER0_COUNT_INPUT,
  output logic TIMER1_COUNT_INPUT,
  output logic EXTERNAL_INTERRUPT_0,
  output logic EXTERNAL_INTERRUPT_1
);
  import pcd_pkg::*;

  pcd_ovr_t ovr [`PCD_NPINS];
  logic [`PCD_NPINS-1:0] port_bits;
  logic [`PCD_NPINS-1:0] dir_bits;
  logic [`PCD_NPINS-1:0] pad_in;
  logic [`PCD_NPINS-1:0] pad_out;
  logic [`PCD_NPINS-1:0] pad_oe_n;
  logic [`PCD_NPINS-1:0] pull_on;
  logic [`PCD_NPINS-1:0] level;
  logic [`PCD_NPINS-1:0] din;
  logic [`PCD_NPINS-1:0] filt;
  logic reset_pin_mode;

  logic [`PCD_NPC-1:0] pinc;
  logic [`PCD_NPC-1:0] portc_rd;
  logic [`PCD_NPC-1:0] ddrc_rd;
  logic [`PCD_NPD-1:0] pind;
  logic reset_n;
  logic scl_in;
  logic sda_in;
  logic [`PCD_NPC-1:0] next_pinc;
  logic [`PCD_NPC-1:0] next_portc_rd;
  logic [`PCD_NPC-1:0] next_ddrc_rd;
  logic [`PCD_NPD-1:0] next_pind;
  logic next_reset_n;
  logic next_scl_in;
  logic next_sda_in;

  assign port_bits = {PORTD_OUTPUT, PORTC_OUTPUT};
  assign dir_bits = {PORTD_DIRECTION, PORTC_DIRECTION};
  assign pad_in = {PORTD_PAD_IN, PORTC_PAD_IN};
  // unprogrammed fuse (1) leaves the pin on the reset circuit
  assign reset_pin_mode = RESET_PIN_DISABLE_FUSE;

  // ****************************************************************
  // override table
  // ****************************************************************
  always_comb
  begin
    for (int i = 0; i < `PCD_NPINS; i++)
    begin
      // analog and plain pins stay unforced
      ovr[i] = '0;
    end
    if (reset_pin_mode)
    begin
      ovr[`PCD_IDX_C6].pullup_override_enable = 1'b1;
      ovr[`PCD_IDX_C6].pullup_override_value = 1'b1;
      ovr[`PCD_IDX_C6].direction_override_enable = 1'b1;
      ovr[`PCD_IDX_C6].direction_override_value = 1'b0;
      ovr[`PCD_IDX_C6].input_enable_override_enable = 1'b1;
      ovr[`PCD_IDX_C6].input_enable_override_value = 1'b0;
    end
    if (TWO_WIRE_ENABLE)
    begin
      ovr[`PCD_IDX_C5].pullup_override_enable = 1'b1;
      ovr[`PCD_IDX_C5].pullup_override_value = PORTC_OUTPUT[`PCD_IDX_C5] & ~GLOBAL_PULLUP_DISABLE;
      ovr[`PCD_IDX_C5].direction_override_enable = 1'b1;
      ovr[`PCD_IDX_C5].direction_override_value = TWO_WIRE_CLOCK_DRIVE;
      ovr[`PCD_IDX_C5].value_override_enable = 1'b1;
      ovr[`PCD_IDX_C5].value_override_value = 1'b0;
      ovr[`PCD_IDX_C4].pullup_override_enable = 1'b1;
      ovr[`PCD_IDX_C4].pullup_override_value = PORTC_OUTPUT[`PCD_IDX_C4] & ~GLOBAL_PULLUP_DISABLE;
      ovr[`PCD_IDX_C4].direction_override_enable = 1'b1;
      ovr[`PCD_IDX_C4].direction_override_value = TWO_WIRE_DATA_DRIVE;
      ovr[`PCD_IDX_C4].value_override_enable = 1'b1;
      ovr[`PCD_IDX_C4].value_override_value = 1'b0;
    end
    if (RECEIVER_ENABLE)
    begin
      ovr[`PCD_IDX_D0].pullup_override_enable = 1'b1;
      ovr[`PCD_IDX_D0].pullup_override_value = PORTD_OUTPUT[0] & ~GLOBAL_PULLUP_DISABLE;
      ovr[`PCD_IDX_D0].direction_override_enable = 1'b1;
      ovr[`PCD_IDX_D0].direction_override_value = 1'b0;
    end
    if (TRANSMITTER_ENABLE)
    begin
      ovr[`PCD_IDX_D1].pullup_override_enable = 1'b1;
      ovr[`PCD_IDX_D1].pullup_override_value = 1'b0;
      ovr[`PCD_IDX_D1].direction_override_enable = 1'b1;
      ovr[`PCD_IDX_D1].direction_override_value = 1'b1;
      ovr[`PCD_IDX_D1].value_override_enable = 1'b1;
      ovr[`PCD_IDX_D1].value_override_value = TRANSMIT_DATA;
    end
    ovr[`PCD_IDX_D2].input_enable_override_enable = EXTERNAL_INTERRUPT_0_ENABLE;
    ovr[`PCD_IDX_D2].input_enable_override_value = 1'b1;
    ovr[`PCD_IDX_D3].input_enable_override_enable = EXTERNAL_INTERRUPT_1_ENABLE;
    ovr[`PCD_IDX_D3].input_enable_override_value = 1'b1;
    ovr[`PCD_IDX_D4].value_override_enable = USART_MODE_SELECT;
    ovr[`PCD_IDX_D4].value_override_value = USART_EXTERNAL_CLOCK_OUT;
  end

  // ****************************************************************
  // per-pin slices
  // ****************************************************************
  for (genvar g = 0; g < `PCD_NPINS; g++)
  begin : g_pin
    pcd_pin_if pif ();
    assign pif.ovr = ovr[g];
    assign pif.port_bit = port_bits[g];
    assign pif.dir_bit = dir_bits[g];
    assign pif.global_pullup_disable = GLOBAL_PULLUP_DISABLE;
    assign pif.sleep = INPUT_SLEEP_DISABLE;
    assign pif.pad_in = pad_in[g];
    assign pad_out[g] = pif.pad_out;
    assign pad_oe_n[g] = pif.pad_oe_n;
    assign pull_on[g] = pif.pull_on;
    assign level[g] = pif.level;
    assign din[g] = pif.din;
    assign filt[g] = pif.filt;
    pcd_pin u_pin (
      .clk (MCLK),
      .rst (RST),
      .p (pif.pin)
    );
  end

  // ****************************************************************
  // readback and peripheral inputs
  // ****************************************************************
  always_comb
  begin
    next_pinc = din[`PCD_NPC-1:0];
    next_portc_rd = PORTC_OUTPUT;
    next_ddrc_rd = PORTC_DIRECTION;
    next_pind = din[`PCD_NPINS-1:`PCD_PD_BASE];
    if (reset_pin_mode)
    begin
      next_pinc[`PCD_IDX_C6] = 1'b0;
      next_portc_rd[`PCD_IDX_C6] = 1'b0;
      next_ddrc_rd[`PCD_IDX_C6] = 1'b0;
    end
    // pin feeds reset only when fuse unprogrammed
    next_reset_n = reset_pin_mode ? level[`PCD_IDX_C6] : `PCD_RST_RESET_N;
    // filtered clock line to the bus
    next_scl_in = TWO_WIRE_ENABLE ? filt[`PCD_IDX_C5] : 1'b1;
    // filtered data line to the bus
    next_sda_in = TWO_WIRE_ENABLE ? filt[`PCD_IDX_C4] : 1'b1;
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      pinc <= '0;
      portc_rd <= '0;
      ddrc_rd <= '0;
      pind <= '0;
      reset_n <= `PCD_RST_RESET_N;
      scl_in <= 1'b1;
      sda_in <= 1'b1;
    end
    else
    begin
      pinc <= next_pinc;
      portc_rd <= next_portc_rd;
      ddrc_rd <= next_ddrc_rd;
      pind <= next_pind;
      reset_n <= next_reset_n;
      scl_in <= next_scl_in;
      sda_in <= next_sda_in;
    end
  end

  // ****************************************************************
  // outputs (all from flip-flops)
  // ****************************************************************
  assign PORTC_PAD_OUT = pad_out[`PCD_NPC-1:0];
  assign PORTC_PAD_OE_N = pad_oe_n[`PCD_NPC-1:0];
  assign PORTC_PULLUP = pull_on[`PCD_NPC-1:0];
  assign PORTD_PAD_OUT = pad_out[`PCD_NPINS-1:`PCD_PD_BASE];
  assign PORTD_PAD_OE_N = pad_oe_n[`PCD_NPINS-1:`PCD_PD_BASE];
  assign PORTD_PULLUP = pull_on[`PCD_NPINS-1:`PCD_PD_BASE];
  assign PORTC_INPUT = pinc;
  assign PORTC_OUTPUT_READ = portc_rd;
  assign PORTC_DIRECTION_READ = ddrc_rd;
  assign PORTD_INPUT = pind;
  assign RESET_PIN_N = reset_n;
  assign TWO_WIRE_CLOCK_IN = scl_in;
  assign TWO_WIRE_DATA_IN = sda_in;
  assign RECEIVE_DATA = din[`PCD_IDX_D0];
  // one input feeds clock and timer 0
  assign USART_EXTERNAL_CLOCK_IN = din[`PCD_IDX_D4];
  assign TIMER0_COUNT_INPUT = din[`PCD_IDX_D4];
  assign TIMER1_COUNT_INPUT = din[`PCD_IDX_D5];
  assign EXTERNAL_INTERRUPT_0 = din[`PCD_IDX_D2];
  assign EXTERNAL_INTERRUPT_1 = din[`PCD_IDX_D3];

endmodule : pcd_mux

/* shared/pcd_cfg.svh */
`ifndef PCD_CFG_SVH
`define PCD_CFG_SVH

// ****************************************************************
// pin count and pin indices (port c at 0..6, port d at 7..14)
// ****************************************************************
`define PCD_NPINS 15
`define PCD_NPC 7
`define PCD_NPD 8
`define PCD_PD_BASE 7
`define PCD_IDX_C4 4
`define PCD_IDX_C5 5
`define PCD_IDX_C6 6
`define PCD_IDX_D0 7
`define PCD_IDX_D1 8
`define PCD_IDX_D2 9
`define PCD_IDX_D3 10
`define PCD_IDX_D4 11
`define PCD_IDX_D5 12

// ****************************************************************
// timing
// ****************************************************************
`define PCD_CLK_PERIOD_NS 50
`define PCD_SPIKE_NS 50
`define PCD_SPIKE_CYC ((`PCD_SPIKE_NS + `PCD_CLK_PERIOD_NS - 1) / `PCD_CLK_PERIOD_NS)
`define PCD_FILT_W 4

// ****************************************************************
// reset values
// ****************************************************************
`define PCD_RST_OE_N 1'b1
`define PCD_RST_LOW 1'b0
`define PCD_RST_RESET_N 1'b1

`endif

/* shared/pcd_pkg.sv */
`include "pcd_cfg.svh"

package pcd_pkg;

  // per-pin override enables and values
  typedef struct packed {
    logic pullup_override_enable;
    logic pullup_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic value_override_enable;
    logic value_override_value;
    logic input_enable_override_enable;
    logic input_enable_override_value;
  } pcd_ovr_t;

  typedef logic [`PCD_FILT_W-1:0] pcd_fcnt_t;

endpackage : pcd_pkg

/* shared/pcd_pin_if.sv */
`timescale 1ns/100ps
`include "pcd_cfg.svh"

interface pcd_pin_if;
  import pcd_pkg::*;
  pcd_ovr_t ovr;
  logic port_bit;
  logic dir_bit;
  logic global_pullup_disable;
  logic sleep;
  logic pad_in;
  logic pad_out;
  logic pad_oe_n;
  logic pull_on;
  logic level;
  logic din;
  logic filt;

  modport ctl (
    output ovr, port_bit, dir_bit, global_pullup_disable, sleep, pad_in,
    input pad_out, pad_oe_n, pull_on, level, din, filt
  );
  modport pin (
    input ovr, port_bit, dir_bit, global_pullup_disable, sleep, pad_in,
    output pad_out, pad_oe_n, pull_on, level, din, filt
  );
endinterface : pcd_pin_if

/* rtl/pcd_pin.sv */
`timescale 1ns/100ps
`include "pcd_cfg.svh"

module pcd_pin (
  input wire logic clk,
  input wire logic rst,
  pcd_pin_if.pin p
);
  import pcd_pkg::*;

  logic s1, s2, s3;
  logic pad_out, pad_oe_n, pull_on, level, din, filt;
  pcd_fcnt_t fcnt;
  logic next_pad_out, next_pad_oe_n, next_pullup, next_level, next_din, next_filt;
  pcd_fcnt_t next_fcnt;
  logic dir, die;

  // ****************************************************************
  // override selection and input conditioning
  // ****************************************************************
  always_comb
  begin
    dir = p.ovr.direction_override_enable ? p.ovr.direction_override_value : p.dir_bit;
    next_pad_out = p.ovr.value_override_enable ? p.ovr.value_override_value : p.port_bit;
    next_pullup = p.ovr.pullup_override_enable ? p.ovr.pullup_override_value : (p.port_bit & ~dir & ~p.global_pullup_disable);
    die = p.ovr.input_enable_override_enable ? p.ovr.input_enable_override_value : ~p.sleep;
    next_pad_oe_n = ~dir;
    // a change counts once second and third stages agree
    next_level = (s2 == s3) ? s3 : level;
    next_din = die & next_level;
    next_fcnt = '0;
    next_filt = filt;
    if (level != filt)
    begin
      if (fcnt >= pcd_fcnt_t'(`PCD_SPIKE_CYC - 1))
      begin
        next_filt = level;
      end
      else
      begin
        next_fcnt = fcnt + pcd_fcnt_t'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1 <= `PCD_RST_LOW;
      s2 <= `PCD_RST_LOW;
      s3 <= `PCD_RST_LOW;
      pad_out <= `PCD_RST_LOW;
      pad_oe_n <= `PCD_RST_OE_N;
      pull_on <= `PCD_RST_LOW;
      level <= `PCD_RST_LOW;
      din <= `PCD_RST_LOW;
      filt <= `PCD_RST_LOW;
      fcnt <= '0;
    end
    else
    begin
      s1 <= p.pad_in;
      s2 <= s1;
      s3 <= s2;
      pad_out <= next_pad_out;
      pad_oe_n <= next_pad_oe_n;
      pull_on <= next_pullup;
      level <= next_level;
      din <= next_din;
      filt <= next_filt;
      fcnt <= next_fcnt;
    end
  end

  assign p.pad_out = pad_out;
  assign p.pad_oe_n = pad_oe_n;
  assign p.pull_on = pull_on;
  assign p.level = level;
  assign p.din = din;
  assign p.filt = filt;

endmodule : pcd_pin

/* verif/pcd_pad_model.sv */
`timescale 1ns/100ps
// ********************
// pad ring and far side
// ********************
module pcd_pad_model #(parameter int W = 7) (
  input wire logic clk,
  input wire logic [W-1:0] pad_out,
  input wire logic [W-1:0] pad_oe_n,
  input wire logic [W-1:0] pull_on,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pad
);
  logic tgl = 1'b0;
  always_ff @(posedge clk)
    tgl <= ~tgl;
  // floating pad without pull-up shows a changing level
  always_comb
    for (int i = 0; i < W; i++)
      pad[i] = !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pull_on[i] ? 1'b1 : tgl ^ i[0];
endmodule : pcd_pad_model

/* verif/pcd_mux_asserts.sv */
`timescale 1ns/100ps
module pcd_mux_asserts (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic RESET_PIN_DISABLE_FUSE,
  input wire logic GLOBAL_PULLUP_DISABLE,
  input wire logic [6:0] PORTC_OUTPUT,
  input wire logic [6:0] PORTC_DIRECTION,
  input wire logic [7:0] PORTD_OUTPUT,
  input wire logic TWO_WIRE_ENABLE,
  input wire logic TWO_WIRE_CLOCK_DRIVE,
  input wire logic TWO_WIRE_DATA_DRIVE,
  input wire logic TRANSMITTER_ENABLE,
  input wire logic TRANSMIT_DATA,
  input wire logic RECEIVER_ENABLE,
  input wire logic USART_MODE_SELECT,
  input wire logic USART_EXTERNAL_CLOCK_OUT,
  input wire logic EXTERNAL_INTERRUPT_0_ENABLE,
  input wire logic [6:0] PORTC_PAD_IN,
  input wire logic [7:0] PORTD_PAD_IN,
  input wire logic [6:0] PORTC_PAD_OUT,
  input wire logic [6:0] PORTC_PAD_OE_N,
  input wire logic [6:0] PORTC_PULLUP,
  input wire logic [7:0] PORTD_PAD_OUT,
  input wire logic [7:0] PORTD_PAD_OE_N,
  input wire logic [7:0] PORTD_PULLUP,
  input wire logic [7:0] PORTD_INPUT,
  input wire logic [6:0] PORTC_INPUT,
  input wire logic [6:0] PORTC_OUTPUT_READ,
  input wire logic [6:0] PORTC_DIRECTION_READ,
  input wire logic TWO_WIRE_CLOCK_IN
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_irq0_held;
    (EXTERNAL_INTERRUPT_0_ENABLE && $stable(PORTD_PAD_IN[2]))[*6];
  endsequence
  sequence s_clk_line_held;
    (TWO_WIRE_ENABLE && $stable(PORTC_PAD_IN[5]))[*8];
  endsequence
  AST_TX_DRIVE: assert property (TRANSMITTER_ENABLE |=> !PORTD_PAD_OE_N[1] && !PORTD_PULLUP[1]
    && PORTD_PAD_OUT[1] == $past(TRANSMIT_DATA)) else $error("tx pin wrong");
  AST_RX_INPUT: assert property (RECEIVER_ENABLE |=> PORTD_PAD_OE_N[0]
    && PORTD_PULLUP[0] == $past(PORTD_OUTPUT[0] & !GLOBAL_PULLUP_DISABLE)) else $error("rx pin wrong");
  AST_RESET_PAD: assert property (RESET_PIN_DISABLE_FUSE |=> PORTC_PULLUP[6] && PORTC_PAD_OE_N[6])
    else $error("reset pin pad wrong");
  AST_RESET_READ: assert property (RESET_PIN_DISABLE_FUSE |=> !PORTC_OUTPUT_READ[6] && !PORTC_DIRECTION_READ[6]
    && !PORTC_INPUT[6])
    else $error("reset pin readback not zero");
  AST_TW_CLOCK: assert property (TWO_WIRE_ENABLE |=> !PORTC_PAD_OUT[5] && PORTC_PAD_OE_N[5] != $past(TWO_WIRE_CLOCK_DRIVE)
    && PORTC_PULLUP[5] == $past(PORTC_OUTPUT[5] & !GLOBAL_PULLUP_DISABLE)) else $error("clock line wrong");
  AST_TW_DATA: assert property (TWO_WIRE_ENABLE |=> !PORTC_PAD_OUT[4] && PORTC_PAD_OE_N[4] != $past(TWO_WIRE_DATA_DRIVE)
    && PORTC_PULLUP[4] == $past(PORTC_OUTPUT[4] & !GLOBAL_PULLUP_DISABLE)) else $error("data line wrong");
  AST_ANALOG: assert property (1'b1 |=> PORTC_PAD_OE_N[3:0] == ~$past(PORTC_DIRECTION[3:0])
    && PORTC_PAD_OUT[3:0] == $past(PORTC_OUTPUT[3:0])) else $error("analog pins overridden");
  AST_XCLK: assert property (USART_MODE_SELECT |=> PORTD_PAD_OUT[4] == $past(USART_EXTERNAL_CLOCK_OUT))
    else $error("clock out pin wrong");
  AST_IRQ0_SENSE: assert property (s_irq0_held |-> PORTD_INPUT[2] == PORTD_PAD_IN[2])
    else $error("irq0 input not sensed");
  AST_TW_FILTER: assert property (s_clk_line_held |-> TWO_WIRE_CLOCK_IN == PORTC_PAD_IN[5])
    else $error("clock line input wrong");
endmodule : pcd_mux_asserts
bind pcd_mux pcd_mux_asserts u_asserts (.*);

/* verif/testbench.sv */
`timescale 1ns/100ps
module testbench;
  logic MCLK, RST, fuse, pu_dis, slp, tw_en, tw_cd, tw_dd, tx_en, tx_data, rx_en, msel, xclk_out, irq0_en, irq1_en;
  logic rst_n, twci, twdi, rx_data, xclk_in, tmr0, tmr1, irq0, irq1;
  logic [6:0] c_o, c_d, c_pad, c_po, c_poe, c_pu, c_in, c_or, c_dr, c_ev, c_ee, cm, ecin;
  logic [7:0] d_o, d_d, d_pad, d_po, d_poe, d_pu, d_in, d_ev, d_ee, edin;
  int mismatches, compares;
  pcd_mux u_dut (.MCLK(MCLK), .RST(RST), .RESET_PIN_DISABLE_FUSE(fuse), .GLOBAL_PULLUP_DISABLE(pu_dis),
    .INPUT_SLEEP_DISABLE(slp), .PORTC_OUTPUT(c_o), .PORTC_DIRECTION(c_d), .PORTD_OUTPUT(d_o), .PORTD_DIRECTION(d_d),
    .TWO_WIRE_ENABLE(tw_en), .TWO_WIRE_CLOCK_DRIVE(tw_cd), .TWO_WIRE_DATA_DRIVE(tw_dd), .TRANSMITTER_ENABLE(tx_en),
    .TRANSMIT_DATA(tx_data), .RECEIVER_ENABLE(rx_en), .USART_MODE_SELECT(msel), .USART_EXTERNAL_CLOCK_OUT(xclk_out),
    .EXTERNAL_INTERRUPT_0_ENABLE(irq0_en), .EXTERNAL_INTERRUPT_1_ENABLE(irq1_en), .PORTC_PAD_IN(c_pad),
    .PORTD_PAD_IN(d_pad), .PORTC_PAD_OUT(c_po), .PORTC_PAD_OE_N(c_poe), .PORTC_PULLUP(c_pu), .PORTD_PAD_OUT(d_po),
    .PORTD_PAD_OE_N(d_poe), .PORTD_PULLUP(d_pu), .PORTC_INPUT(c_in), .PORTC_OUTPUT_READ(c_or),
    .PORTC_DIRECTION_READ(c_dr), .PORTD_INPUT(d_in), .RESET_PIN_N(rst_n), .TWO_WIRE_CLOCK_IN(twci),
    .TWO_WIRE_DATA_IN(twdi), .RECEIVE_DATA(rx_data), .USART_EXTERNAL_CLOCK_IN(xclk_in), .TIMER0_COUNT_INPUT(tmr0),
    .TIMER1_COUNT_INPUT(tmr1), .EXTERNAL_INTERRUPT_0(irq0), .EXTERNAL_INTERRUPT_1(irq1));
  pcd_pad_model #(.W(7)) u_pads_c (.clk(MCLK), .pad_out(c_po), .pad_oe_n(c_poe), .pull_on(c_pu), .ext_en(c_ee),
    .ext_val(c_ev), .pad(c_pad));
  pcd_pad_model #(.W(8)) u_pads_d (.clk(MCLK), .pad_out(d_po), .pad_oe_n(d_poe), .pull_on(d_pu), .ext_en(d_ee),
    .ext_val(d_ev), .pad(d_pad));
  // ********************
  // expectations and checks
  // ********************
  function automatic logic [23:0] exp_c();
    logic [6:0] o, oe, pu;
    o = c_o;
    oe = ~c_d;
    pu = c_o & ~c_d & {7{~pu_dis}};
    if (fuse)
      {pu[6], oe[6]} = 2'h3;
    if (tw_en)
    begin
      o[5:4] = 2'h0;
      oe[5:4] = {~tw_cd, ~tw_dd};
      pu[5:4] = c_o[5:4] & {2{~pu_dis}};
    end
    return {3'h0, o, oe, pu};
  endfunction : exp_c
  function automatic logic [23:0] exp_d();
    logic [7:0] o, oe, pu;
    o = d_o;
    oe = ~d_d;
    pu = d_o & ~d_d & {8{~pu_dis}};
    if (rx_en)
      {oe[0], pu[0]} = {1'b1, d_o[0] & ~pu_dis};
    if (tx_en)
      {o[1], oe[1], pu[1]} = {tx_data, 2'h0};
    if (msel)
      o[4] = xclk_out;
    return {o, oe, pu};
  endfunction : exp_d
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic do_reset(input int n);
    RST = 1'b1;
    repeat (n) @(negedge MCLK);
    check("reset_c", {c_po, c_poe, c_pu, rst_n, twci, twdi}, {7'h00, 7'h7f, 7'h00, 3'h7});
    check("reset_d", {d_po, d_poe, d_pu}, {8'h00, 8'hff, 8'h00});
    RST = 1'b0;
  endtask : do_reset
  // ********************
  // clock, watchdog, main sequence
  // ********************
  initial
  begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  initial
  begin
    #5000000;
    mismatches++;
    tally_and_finish();
  end
  initial
  begin
    {RST, fuse, pu_dis, slp, tw_en, tw_cd, tw_dd, tx_en, tx_data, rx_en, msel, xclk_out, irq0_en, irq1_en} = 14'h2000;
    {c_o, c_d, c_ev, d_o, d_d, d_ev} = '0;
    c_ee = 7'h7f;
    d_ee = 8'hff;
    mismatches = 0;
    compares = 0;
    void'($urandom(32'h2c32c343));
    do_reset(8);
    for (int i = 0; i < 60; i++)
    begin
      if (i == 30)
        do_reset(2);
      @(negedge MCLK);
      {fuse, pu_dis, slp, tw_en, tw_cd, tw_dd, tx_en, tx_data, rx_en, msel, xclk_out, irq0_en, irq1_en} = 13'($urandom);
      {c_o, c_d, c_ev} = 21'($urandom);
      {d_o, d_d, d_ev} = 24'($urandom);
      c_ee = (i == 3) ? 7'h00 : 7'h7f;
      {d_o[7:6], d_d[7:6]} = 4'h0;
      if (i == 1)
        {fuse, tw_en, tx_en, rx_en, msel, irq0_en, irq1_en, slp} = 8'hfe;
      if (i == 2)
        {fuse, tw_en, tx_en, rx_en, msel, slp, pu_dis} = 7'h03;
      @(negedge MCLK);
      check("portc_pads", {3'h0, c_po, c_poe, c_pu}, exp_c());
      check("portd_pads", {d_po, d_poe, d_pu}, exp_d());
      check("portc_read", {10'h0, c_or, c_dr}, {10'h0, ~fuse & c_o[6], c_o[5:0], ~fuse & c_d[6], c_d[5:0]});
      if (c_ee == 7'h7f)
      begin
        repeat (9) @(negedge MCLK);
        cm = tw_en ? 7'h4f : 7'h7f;
        ecin = slp ? 7'h00 : {~fuse & c_pad[6], c_pad[5:0]};
        edin = slp ? {4'h0, irq1_en & d_pad[3], irq0_en & d_pad[2], 2'h0} : d_pad;
        check("portc_in", {17'h0, c_in & cm}, {17'h0, ecin & cm});
        check("portd_in", {16'h0, d_in}, {16'h0, edin});
        check("periph_in", {18'h0, rst_n, twci, twdi, tmr1, tmr0, irq0},
          {18'h0, ~fuse | c_pad[6], ~tw_en | c_pad[5], ~tw_en | c_pad[4], ~slp & d_pad[5], ~slp & d_pad[4],
          (irq0_en | ~slp) & d_pad[2]});
        check("usart_in", {21'h0, rx_data, xclk_in, irq1},
          {21'h0, ~slp & d_pad[0], ~slp & d_pad[4], (irq1_en | ~slp) & d_pad[3]});
      end
      $display("test %0d done", i);
    end
    tally_and_finish();
  end
endmodule : testbench
